// >>> core/dbpm_map.vh
// Constants for the drop bus parity and frame pulse pin mux
`ifndef DBPM_MAP_VH
`define DBPM_MAP_VH
`define DBPM_CTRL_ADDR 16'h013B
`define DBPM_CTRL_RESET 8'h00
`define DBPM_CTRL_ODD_BIT 0
`define DBPM_CTRL_WIDE_BIT 1
`define DBPM_CTRL_EN_LSB 4
`define DBPM_LANES 4
`define DBPM_MODE_DS3E3 1'b0
`define DBPM_MODE_STS1 1'b1
`endif

// >>> core/dbpm_lane.v
// One drop lane: phase marker, payload indicator and parity
`default_nettype none
module dbpm_lane (
  // Clock and reset
  input wire sys_clk,
  input wire srst,
  // Lane timing and data
  input wire drop_clock_rise,
  input wire [7:0] lane_data,
  input wire lane_toh,
  input wire lane_c1,
  input wire lane_j1,
  // Parity setting
  input wire parity_odd,
  input wire parity_wide,
  // Bus outputs
  output reg [7:0] drop_data_bus,
  output reg drop_payload_indicator,
  output reg phase_marker,
  output reg parity
);
  wire next_payload;
  wire next_marker;
  wire data_par;
  wire next_parity;

  assign next_payload = ~lane_toh;
  // C1 only in overhead, J1 only in payload
  assign next_marker = (lane_c1 & lane_toh) | (lane_j1 & ~lane_toh);
  assign data_par = ^lane_data;
  // Same-cycle coverage of byte and indicators
  assign next_parity = data_par ^ parity_odd ^
    (parity_wide & (next_payload ^ next_marker));

  always @(posedge sys_clk) begin
    if (srst) begin
      drop_data_bus <= 8'h00;
      drop_payload_indicator <= 1'b0;
      phase_marker <= 1'b0;
      parity <= 1'b0;
    end else if (drop_clock_rise) begin
      drop_data_bus <= lane_data;
      drop_payload_indicator <= next_payload;
      phase_marker <= next_marker;
      parity <= next_parity;
    end
  end
endmodule
`default_nettype wire

// >>> core/dbpm_top.v
// Drop bus parity and frame pulse pin mux, top level
// What this block does
// - A shared pin carries its bus function if its lane is on, else a pulse.
// - Parity covers the eight drop data bits, even or odd as configured.
// - Wide parity also covers the payload indicator and phase marker states.
// - With the lane off, channel mode picks egress or STS-1 frame pulse.
// - The egress pulse is high one line bit period on the first frame bit.
// - The STS-1 pulse is high one bit period on the very first frame bit.
// - Phase marker pins of lanes 0 to 3 carry channels 8 to 11 pulses.
// - Parity pin of lane 0 carries channel 4 pulse when lane 0 is off.
// - Payload indicator is low on overhead bytes and high otherwise.
// - Phase marker pulses one drop clock on C1 (overhead) and J1 (payload).
`default_nettype none
`include "dbpm_map.vh"
module dbpm_top (
  // Clock and reset
  input wire sys_clk,
  input wire srst,
  // Register port
  input wire [15:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  output reg [7:0] reg_rdata,
  // Drop clock pin and lane sources
  input wire drop_clock,
  input wire [31:0] lane_data,
  input wire [3:0] lane_toh,
  input wire [3:0] lane_c1,
  input wire [3:0] lane_j1,
  output wire [31:0] drop_data_bus,
  output wire [3:0] drop_payload_indicator,
  // Channel 4 and 8 to 11 line side, index 0 is channel 4
  input wire [4:0] line_bit_clock,
  input wire [4:0] frame_first_bit,
  input wire [4:0] chan_mode,
  // Shared pins
  output wire [3:0] drop_phase_marker_out,
  output wire drop_parity_out,
  // Frame pulses seen separately
  output wire [4:0] egress_frame_pulse_out,
  output wire [4:0] tx_overhead_frame_pulse_out
);
  reg [7:0] drop_bus_control;
  reg [1:0] dclk_sync;
  reg dclk_last;
  wire dclk_rise;
  wire [3:0] lane_en;
  wire [3:0] marker;
  wire [3:0] par;
  reg [4:0] lclk_s1;
  reg [4:0] lclk_s2;
  reg [4:0] lclk_last;
  reg [4:0] ffb_s1;
  reg [4:0] ffb_s2;
  reg [4:0] frame_pulse;
  reg [31:0] lane_data_s1;
  reg [31:0] lane_data_s2;
  reg [3:0] lane_toh_s1;
  reg [3:0] lane_toh_s2;
  reg [3:0] lane_c1_s1;
  reg [3:0] lane_c1_s2;
  reg [3:0] lane_j1_s1;
  reg [3:0] lane_j1_s2;

  // Register port, single control register
  always @(posedge sys_clk) begin
    if (srst)
      drop_bus_control <= `DBPM_CTRL_RESET;
    else if (reg_wr && reg_addr == `DBPM_CTRL_ADDR)
      drop_bus_control <= reg_wdata;
  end

  always @(posedge sys_clk) begin
    if (srst)
      reg_rdata <= 8'h00;
    else if (reg_addr == `DBPM_CTRL_ADDR)
      reg_rdata <= drop_bus_control;
    else
      reg_rdata <= 8'h00;
  end

  assign lane_en = drop_bus_control[`DBPM_CTRL_EN_LSB +: `DBPM_LANES];

  // Drop clock edge finder
  always @(posedge sys_clk) begin
    if (srst) begin
      dclk_sync <= 2'b00;
      dclk_last <= 1'b0;
    end else begin
      dclk_sync <= {dclk_sync[0], drop_clock};
      dclk_last <= dclk_sync[1];
    end
  end
  assign dclk_rise = dclk_sync[1] & ~dclk_last;

  // Lane sources through two flops, steady long before the load edge
  always @(posedge sys_clk) begin
    if (srst) begin
      lane_data_s1 <= 32'h00000000;
      lane_data_s2 <= 32'h00000000;
      lane_toh_s1 <= 4'h0;
      lane_toh_s2 <= 4'h0;
      lane_c1_s1 <= 4'h0;
      lane_c1_s2 <= 4'h0;
      lane_j1_s1 <= 4'h0;
      lane_j1_s2 <= 4'h0;
    end else begin
      lane_data_s1 <= lane_data;
      lane_data_s2 <= lane_data_s1;
      lane_toh_s1 <= lane_toh;
      lane_toh_s2 <= lane_toh_s1;
      lane_c1_s1 <= lane_c1;
      lane_c1_s2 <= lane_c1_s1;
      lane_j1_s1 <= lane_j1;
      lane_j1_s2 <= lane_j1_s1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `DBPM_LANES; g = g + 1) begin : lane
      dbpm_lane u_lane (
        .sys_clk(sys_clk),
        .srst(srst),
        .drop_clock_rise(dclk_rise),
        .lane_data(lane_data_s2[8*g +: 8]),
        .lane_toh(lane_toh_s2[g]),
        .lane_c1(lane_c1_s2[g]),
        .lane_j1(lane_j1_s2[g]),
        .parity_odd(drop_bus_control[`DBPM_CTRL_ODD_BIT]),
        .parity_wide(drop_bus_control[`DBPM_CTRL_WIDE_BIT]),
        .drop_data_bus(drop_data_bus[8*g +: 8]),
        .drop_payload_indicator(drop_payload_indicator[g]),
        .phase_marker(marker[g]),
        .parity(par[g])
      );
    end
  endgenerate

  // Line side: a pulse one line bit period long on the first frame bit
  always @(posedge sys_clk) begin
    if (srst) begin
      lclk_s1 <= 5'h00;
      lclk_s2 <= 5'h00;
      lclk_last <= 5'h00;
      ffb_s1 <= 5'h00;
      ffb_s2 <= 5'h00;
      frame_pulse <= 5'h00;
    end else begin
      lclk_s1 <= line_bit_clock;
      lclk_s2 <= lclk_s1;
      lclk_last <= lclk_s2;
      ffb_s1 <= frame_first_bit;
      ffb_s2 <= ffb_s1;
      // Updated once per line bit, so it stands one bit period
      frame_pulse <= (frame_pulse & ~(lclk_s2 & ~lclk_last)) |
        (ffb_s2 & lclk_s2 & ~lclk_last);
    end
  end

  generate
    for (g = 0; g < 5; g = g + 1) begin : chan
      assign egress_frame_pulse_out[g] =
        frame_pulse[g] & (chan_mode[g] == `DBPM_MODE_DS3E3);
      assign tx_overhead_frame_pulse_out[g] =
        frame_pulse[g] & (chan_mode[g] == `DBPM_MODE_STS1);
    end
    for (g = 0; g < `DBPM_LANES; g = g + 1) begin : pin
      assign drop_phase_marker_out[g] =
        lane_en[g] ? marker[g] : frame_pulse[g + 1];
    end
  endgenerate

  assign drop_parity_out = lane_en[0] ? par[0] : frame_pulse[0];
endmodule
`default_nettype wire

// >>> tb/dbpm_far.sv
// Far-side model: drop bus source and line bit timing
`default_nettype none
module dbpm_far (
  // Clocks and frame start
  output logic drop_clock,
  output logic [4:0] line_bit_clock,
  output logic [4:0] frame_first_bit,
  // Lane sources
  output logic [31:0] lane_data,
  output logic [3:0] lane_toh,
  output logic [3:0] lane_c1,
  output logic [3:0] lane_j1
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] n = 8'h01;
  initial drop_clock = 1'b0;
  always #62.5 drop_clock = ~drop_clock;
  assign line_bit_clock = {5{drop_clock}}; // Drop clock doubles as all five line bit clocks
  // Bytes change on the falling edge, held a full period
  always @(negedge drop_clock) n <= n + 8'h01;
  assign lane_data = {n, ~n, n, ~n};
  assign lane_toh = {4{n[1:0] == 2'h0}};
  assign lane_c1 = {4{n[2:0] == 3'h0}};
  assign lane_j1 = {4{n[2:0] == 3'h5}};
  assign frame_first_bit = {5{n[3:0] == 4'h0}};
endmodule
`default_nettype wire

// >>> tb/dbpm_chk.sv
// Assertion checker for the drop bus pin mux
`default_nettype none
`include "dbpm_map.vh"
module dbpm_chk (
  // Watched ports
  input wire logic sys_clk, srst, reg_wr, drop_parity_out,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata, reg_rdata,
  input wire logic [3:0] lane_toh, drop_payload_indicator,
  input wire logic [3:0] drop_phase_marker_out,
  input wire logic [31:0] drop_data_bus,
  input wire logic [4:0] chan_mode, egress_frame_pulse_out,
  input wire logic [4:0] tx_overhead_frame_pulse_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] ctl;
  logic [4:0] age;
  wire wen = reg_wr && reg_addr == `DBPM_CTRL_ADDR;
  wire ok = age == 5'h1F;
  wire [4:0] eg = egress_frame_pulse_out;
  wire [4:0] tx = tx_overhead_frame_pulse_out;
  wire [4:0] fp = chan_mode & tx | ~chan_mode & eg;
  wire [3:0] off = ~ctl[7:4];
  wire pe = ^drop_data_bus[7:0] ^ ctl[0] ^ ctl[1] &
    (drop_payload_indicator[0] ^ drop_phase_marker_out[0]);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  // Settle time after a control write
  always @(posedge sys_clk) begin
    ctl <= srst ? `DBPM_CTRL_RESET : wen ? reg_wdata : ctl;
    age <= srst || wen ? 5'h00 : age + {4'h0, !ok};
  end
  sequence s_load;
    $changed(drop_data_bus[7:0]) && ctl[4] && ok;
  endsequence
  sequence s_bit(x);
    x[*8] ##1 x[*7] ##[1:2] !x;
  endsequence
  a_par_value: assert property (ok && ctl[4] |->
    drop_parity_out == pe) else $error("parity wrong");
  a_par_pulse: assert property (ok && !ctl[4] |->
    drop_parity_out == fp[0]) else $error("parity pin wrong");
  a_mark_pulse: assert property (ok |->
    (drop_phase_marker_out & off) == (fp[4:1] & off)) else $error("marker");
  a_pl_toh: assert property (s_load |->
    drop_payload_indicator[0] == !lane_toh[0]) else $error("payload");
  a_mode_gate: assert property (
    (eg & chan_mode | tx & ~chan_mode) == 5'h00) else $error("mode gate");
  a_eg_width: assert property ($rose(eg[0]) |-> s_bit(eg[0]))
    else $error("egress width");
  a_tx_width: assert property ($rose(tx[1]) |-> s_bit(tx[1]))
    else $error("sts1 width");
  a_rd_ctl: assert property (!reg_wr && reg_addr == `DBPM_CTRL_ADDR |=>
    reg_rdata == ctl) else $error("readback");
endmodule
bind dbpm_top dbpm_chk u_chk (.*);
`default_nettype wire

// >>> tb/test_dbpm_top.sv
// Self-checking bench for the drop bus pin mux
`default_nettype none
module test_dbpm_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic [4:0] chan_mode = 5'h00;
  wire drop_clock, drop_parity_out;
  wire [7:0] reg_rdata;
  wire [31:0] lane_data, drop_data_bus;
  wire [3:0] lane_toh, lane_c1, lane_j1, drop_payload_indicator;
  wire [3:0] drop_phase_marker_out;
  wire [4:0] line_bit_clock, frame_first_bit, egress_frame_pulse_out;
  wire [4:0] tx_overhead_frame_pulse_out;
  int num_errors = 0, comparisons = 0, cyc = 0;
  dbpm_far far (.*);
  dbpm_top dut (.*);
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      close_out();
    end
  end
  task automatic chk(input logic [7:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Write when w is set, else read and compare against d
  task automatic acc(input logic [15:0] a, input logic [7:0] d, input bit w);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    if (!w) chk(reg_rdata, d);
  endtask
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    logic t, k;
    repeat (8) @(negedge sys_clk);
    srst = 1'b0;
    acc(16'h013B, 8'h00, 1'b0);
    acc(16'h013C, 8'hFF, 1'b1);
    acc(16'h013C, 8'h00, 1'b0);
    acc(16'h013B, 8'h00, 1'b0);
    $display("Register test done");
    for (int m = 0; m < 2; m++) begin
      @(negedge frame_first_bit[0]);
      repeat (40) @(negedge sys_clk);
      chan_mode = {5{m[0]}};
      @(posedge drop_parity_out);
      @(negedge sys_clk);
      chk({3'h0, egress_frame_pulse_out}, m ? 8'h00 : 8'h1F);
      chk({3'h0, tx_overhead_frame_pulse_out}, m ? 8'h1F : 8'h00);
      chk({3'h0, drop_phase_marker_out, drop_parity_out}, 8'h1F);
      repeat (20) @(negedge sys_clk);
      chk({3'h0, drop_phase_marker_out, drop_parity_out}, 8'h00);
      $display("Pulse mode %0d test done", m);
    end
    for (int p = 0; p < 4; p++) begin
      acc(16'h013B, {6'h3C, p[1:0]}, 1'b1);
      acc(16'h013B, {6'h3C, p[1:0]}, 1'b0);
      repeat (40) @(negedge sys_clk);
      repeat (8) begin
        @(drop_data_bus[7:0]);
        @(negedge sys_clk);
        t = lane_toh[0];
        k = lane_c1[0] & t | lane_j1[0] & !t;
        chk({drop_phase_marker_out, drop_payload_indicator},
          {{4{k}}, {4{!t}}});
        chk({7'h00, drop_parity_out}, {7'h00,
          (^lane_data[7:0]) ^ p[0] ^ (p[1] & (!t ^ k))});
        for (int i = 0; i < 4; i++)
          chk(drop_data_bus[8*i +: 8], lane_data[8*i +: 8]);
      end
      $display("Parity setting %0d test done", p);
    end
    close_out();
  end
endmodule
`default_nettype wire
